// ---- rtl/occ_pkg.sv ----
/*
 * package for the output compare channel: register map, field positions,
 * mode and clock-select codes, carrier structs.
 * assumes an ahb-lite slave with 32-bit data, one aligned word per register.
 */
package occ_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [7:0] OCC_ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] OCC_ADDR_PRI = 8'h04;
  localparam logic [7:0] OCC_ADDR_SEC = 8'h08;
  localparam logic [7:0] OCC_ADDR_TMR = 8'h0C;
  localparam logic [7:0] OCC_ADDR_CTRL2 = 8'h10;
  localparam logic [7:0] OCC_ADDR_ISTAT = 8'h14;
  localparam logic [7:0] OCC_ADDR_IMASK = 8'h18;

  // ************************************************************
  // control one fields
  // ************************************************************
  localparam int OCC_C1_SIDL = 13;
  localparam int OCC_C1_TSEL_LO = 10;
  localparam int OCC_C1_FLTEN = 7;
  localparam int OCC_C1_FLTST = 4;
  localparam int OCC_C1_TRGMD = 3;
  localparam int OCC_C1_MODE_LO = 0;
  // implemented bits of control one: 13..10, 7, 4..0
  localparam logic [15:0] OCC_C1_IMPL = 16'h3C9F;
  localparam logic [15:0] OCC_C1_RESET = 16'h0000;

  // control two fields (trigger status and trigger/sync enable)
  localparam int OCC_C2_TRGEN = 7;
  localparam int OCC_C2_TRGST = 6;
  localparam logic [15:0] OCC_C2_RESET = 16'h0080;

  // interrupt status / mask bits
  localparam int OCC_IRQ_PRI = 0;
  localparam int OCC_IRQ_SEC = 1;
  localparam int OCC_IRQ_FLT = 2;
  localparam int OCC_NIRQ = 3;

  // ************************************************************
  // codes
  // ************************************************************
  typedef enum logic [2:0] {
    OCC_M_OFF = 3'b000,
    OCC_M_SS_HI = 3'b001,
    OCC_M_SS_LO = 3'b010,
    OCC_M_TOGGLE = 3'b011,
    OCC_M_DUAL_SS = 3'b100,
    OCC_M_DUAL_CONT = 3'b101,
    OCC_M_PWM_EDGE = 3'b110,
    OCC_M_PWM_CTR = 3'b111
  } occ_mode_t;

  localparam logic [2:0] OCC_TS_T2 = 3'b000;
  localparam logic [2:0] OCC_TS_T3 = 3'b001;
  localparam logic [2:0] OCC_TS_T4 = 3'b010;
  localparam logic [2:0] OCC_TS_T5 = 3'b011;
  localparam logic [2:0] OCC_TS_T1 = 3'b100;
  localparam logic [2:0] OCC_TS_FP = 3'b111;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic trig2; // timer two trigger event (default sync source)
    logic trig_other; // alternative sync source event
  } occ_trig_t;

  typedef struct packed {
    logic [4:0] tick; // timer1..timer5 clock ticks, bit0 = timer1
  } occ_ticks_t;

endpackage : occ_pkg

// ---- rtl/occ_sync.sv ----
/*
 * three-stage pin synchroniser with agreement filter.
 * assumes an asynchronous level input; output changes when stages two and three agree.
 */
`timescale 1ns/10ps
module occ_sync (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic pin_in, // asynchronous level
  output logic level_o // filtered level
);
  import occ_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } occ_sync_st_t;

  occ_sync_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;
endmodule : occ_sync

// ---- rtl/occ_channel.sv ----
/*
 * output compare channel with ahb-lite register slave and interrupt.
 * assumes timer ticks and trigger events are one-cycle pulses on hclk;
 * the fault pin and idle request are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
// How it works
// - compare counter with one or two values, count set by mode
// - output pin changes level on match, single pulse or pulse train
// - compare matches can raise an interrupt request
// - six clock sources: peripheral clock and timers one to five
// - clock select 000..011 timers two to five, 111 peripheral, 101/110 reserved
// - code 100 selects timer one, synchronous clock only
// - idle-stop bit set halts channel during idle, clear keeps running
// - fault enable bit gates the fault input
// - fault status reads one after fault; hardware and software may write it
// - clear mode one: trigger flag clears on secondary match or software
// - compare values double-buffered only in pwm modes
// - trigger/sync source enabled and timer two after reset
// - unimplemented control bits read zero; implemented reset to zero, except trigger/sync enable which resets to one
// - mode field: off, single compare, dual compare, edge and center pwm
// - trigger flag one while running, zero while held clear
module occ_channel #(
  parameter int CNT_W = 16 // time base width
) (
  input wire logic hclk, // bus and peripheral clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire occ_pkg::occ_ticks_t ticks, // timer clock ticks
  input wire occ_pkg::occ_trig_t trig, // trigger/sync events
  input wire logic cpu_idle, // processor in idle mode (async)
  input wire logic fault_a_input_pin, // fault a input, active high (async)
  output logic compare_output_pin, // compare output
  output logic irq // level interrupt
);
  import occ_pkg::*;

  initial begin
    if (CNT_W < 2 || CNT_W > 16) begin
      $error("occ_channel: CNT_W must be 2..16");
    end
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] ctrl1; // compare_control_one
    logic trg_en; // trigger/sync enable
    logic trg_st; // trigger_status_flag
    logic [CNT_W-1:0] pri_wr; // primary_compare_value as written
    logic [CNT_W-1:0] sec_wr; // secondary_compare_value as written
    logic [CNT_W-1:0] pri_act; // values the comparator uses
    logic [CNT_W-1:0] sec_act;
    logic [CNT_W-1:0] cnt; // compare_timebase_counter
    logic out; // pin level
    logic shot_done; // single-shot finished
    logic dual_ph; // dual compare: waiting for secondary
    logic [OCC_NIRQ-1:0] istat;
    logic [OCC_NIRQ-1:0] imask;
    logic irq;
    logic ap_valid; // latched address phase
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic [2:0] prev_mode;
  } occ_st_t;

  occ_st_t st_q, st_d;
  logic idle_s, fault_s;

  occ_sync u_idle_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(cpu_idle),
    .level_o(idle_s)
  );

  occ_sync u_fault_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(fault_a_input_pin),
    .level_o(fault_s)
  );

  // ************************************************************
  // next state
  // ************************************************************
  occ_mode_t mode;
  logic [2:0] tsel;
  logic tick, is_pwm, run, at_pri, at_sec, at_top, fault_hit;
  logic rd_stat;
  logic [OCC_NIRQ-1:0] ev;
  logic [CNT_W-1:0] wdat;

  always_comb begin
    st_d = st_q;
    mode = occ_mode_t'(st_q.ctrl1[OCC_C1_MODE_LO +: 3]);
    tsel = st_q.ctrl1[OCC_C1_TSEL_LO +: 3];
    wdat = hwdata[CNT_W-1:0];
    // clock source select; reserved codes give no tick
    unique case (tsel)
      OCC_TS_T2: tick = ticks.tick[1];
      OCC_TS_T3: tick = ticks.tick[2];
      OCC_TS_T4: tick = ticks.tick[3];
      OCC_TS_T5: tick = ticks.tick[4];
      OCC_TS_T1: tick = ticks.tick[0]; // synchronous tick only
      OCC_TS_FP: tick = 1'b1;
      default: tick = 1'b0;
    endcase
    is_pwm = (mode == OCC_M_PWM_EDGE) || (mode == OCC_M_PWM_CTR);
    // halted in idle only when idle-stop is set
    run = (mode != OCC_M_OFF) && !(st_q.ctrl1[OCC_C1_SIDL] && idle_s);
    at_pri = st_q.cnt == st_q.pri_act;
    at_sec = st_q.cnt == st_q.sec_act;
    at_top = is_pwm ? at_sec : 1'b0;
    fault_hit = st_q.ctrl1[OCC_C1_FLTEN] && fault_s && is_pwm;
    rd_stat = 1'b0;
    ev = {OCC_NIRQ{1'b0}};

    // trigger: source event starts the time base
    if (st_q.trg_en && (trig.trig2 || trig.trig_other)) begin
      st_d.trg_st = 1'b1;
    end else if (!st_q.trg_en) begin
      st_d.trg_st = 1'b1; // no source: free running
    end

    // entering a mode initialises the pin and sequence
    if (st_q.prev_mode != st_q.ctrl1[OCC_C1_MODE_LO +: 3]) begin
      st_d.cnt = '0;
      st_d.shot_done = 1'b0;
      st_d.dual_ph = 1'b0;
      st_d.out = (mode == OCC_M_SS_LO);
      st_d.pri_act = st_q.pri_wr;
      st_d.sec_act = st_q.sec_wr;
    end else if (!st_q.trg_st) begin
      st_d.cnt = '0; // held clear until triggered
    end else if (run && tick) begin
      st_d.cnt = st_q.cnt + 1'b1;
      unique case (mode)
        OCC_M_SS_HI: if (at_pri && !st_q.shot_done) begin
          st_d.out = 1'b1;
          st_d.shot_done = 1'b1;
        end
        OCC_M_SS_LO: if (at_pri && !st_q.shot_done) begin
          st_d.out = 1'b0;
          st_d.shot_done = 1'b1;
        end
        OCC_M_TOGGLE: if (at_pri) begin
          st_d.out = !st_q.out;
        end
        OCC_M_DUAL_SS, OCC_M_DUAL_CONT: begin
          if (!st_q.shot_done && !st_q.dual_ph && at_pri) begin
            st_d.out = 1'b1;
            st_d.dual_ph = 1'b1;
          end else if (st_q.dual_ph && at_sec) begin
            st_d.out = 1'b0;
            st_d.dual_ph = 1'b0;
            st_d.shot_done = (mode == OCC_M_DUAL_SS);
          end
        end
        OCC_M_PWM_EDGE: begin
          if (at_pri) begin
            st_d.out = 1'b0;
          end
          if (st_q.cnt == '0 && st_q.pri_act != '0) begin
            st_d.out = 1'b1;
          end
        end
        OCC_M_PWM_CTR: begin
          if (at_pri) begin
            st_d.out = 1'b1;
          end
          if (at_sec) begin
            st_d.out = 1'b0;
          end
        end
        default: st_d.out = st_q.out;
      endcase
      // period end in pwm: wrap and load shadow values
      if (at_top) begin
        st_d.cnt = '0;
        st_d.pri_act = st_q.pri_wr;
        st_d.sec_act = st_q.sec_wr;
      end
      if (at_pri) begin
        ev[OCC_IRQ_PRI] = 1'b1;
      end
      if (at_sec && (mode >= OCC_M_DUAL_SS)) begin
        ev[OCC_IRQ_SEC] = 1'b1;
      end
      if (at_sec && st_q.ctrl1[OCC_C1_TRGMD] && st_q.trg_en) begin
        st_d.trg_st = 1'b0;
      end
    end
    if (mode == OCC_M_OFF) begin
      st_d.out = 1'b0;
    end

    // ************************************************************
    // ahb-lite slave: zero wait states
    // ************************************************************
    if (st_q.ap_valid && st_q.ap_write) begin
      unique case (st_q.ap_addr)
        OCC_ADDR_CTRL1: st_d.ctrl1 = hwdata[15:0] & OCC_C1_IMPL;
        OCC_ADDR_PRI: begin
          st_d.pri_wr = wdat;
          if (!is_pwm) st_d.pri_act = wdat;
        end
        OCC_ADDR_SEC: begin
          st_d.sec_wr = wdat;
          if (!is_pwm) st_d.sec_act = wdat;
        end
        OCC_ADDR_TMR: st_d.cnt = wdat;
        OCC_ADDR_CTRL2: begin
          st_d.trg_en = hwdata[OCC_C2_TRGEN];
          // a trigger arriving with a software clear still sets the flag
          st_d.trg_st = hwdata[OCC_C2_TRGST] || (st_q.trg_en && (trig.trig2 || trig.trig_other));
        end
        OCC_ADDR_IMASK: st_d.imask = hwdata[OCC_NIRQ-1:0];
        default: st_d.rdata = st_q.rdata;
      endcase
    end
    // fault: set wins over software write in the same cycle
    if (fault_hit) begin
      st_d.ctrl1[OCC_C1_FLTST] = 1'b1;
      st_d.out = 1'b0;
      ev[OCC_IRQ_FLT] = 1'b1;
    end

    st_d.ap_valid = hsel && hready && htrans[1];
    st_d.ap_write = hwrite;
    st_d.ap_addr = haddr[7:0];
    st_d.rdata = '0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        OCC_ADDR_CTRL1: st_d.rdata = {16'h0000, st_d.ctrl1 & OCC_C1_IMPL};
        OCC_ADDR_PRI: st_d.rdata[CNT_W-1:0] = st_q.pri_wr;
        OCC_ADDR_SEC: st_d.rdata[CNT_W-1:0] = st_q.sec_wr;
        OCC_ADDR_TMR: st_d.rdata[CNT_W-1:0] = st_q.cnt;
        OCC_ADDR_CTRL2: begin
          st_d.rdata[OCC_C2_TRGEN] = st_q.trg_en;
          st_d.rdata[OCC_C2_TRGST] = st_q.trg_st;
        end
        OCC_ADDR_ISTAT: begin
          st_d.rdata[OCC_NIRQ-1:0] = st_q.istat;
          rd_stat = 1'b1;
        end
        OCC_ADDR_IMASK: st_d.rdata[OCC_NIRQ-1:0] = st_q.imask;
        default: st_d.rdata = '0;
      endcase
    end
    // read clears what was reported; an event in the same cycle still lands
    st_d.istat = (rd_stat ? {OCC_NIRQ{1'b0}} : st_q.istat) | ev;
    st_d.irq = |(st_d.istat & st_d.imask);
    // mode taken from the register, so a freshly written mode counts as a change
    st_d.prev_mode = st_q.ctrl1[OCC_C1_MODE_LO +: 3];
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.ctrl1 <= OCC_C1_RESET;
      st_q.trg_en <= OCC_C2_RESET[OCC_C2_TRGEN];
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign compare_output_pin = st_q.out;
  assign irq = st_q.irq;
endmodule : occ_channel

// ---- verif/occ_load_model.sv ----
/* load on the compare output pin: counts level changes.
   assumes a push-pull pin sampled on hclk. */
`timescale 1ns/10ps
module occ_load_model (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic pin, // compare output
  input wire logic clr, // restart count
  output logic [7:0] edges // changes seen
);
  logic pin_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b0;
      edges <= 8'h00;
    end else begin
      pin_q <= pin;
      edges <= clr ? 8'h00 : edges + 8'(pin != pin_q);
    end
  end
endmodule : occ_load_model

// ---- verif/occ_channel_properties.sv ----
/* checker on the channel ports.
   assumes zero-wait bus; control writes land after their data phase. */
`timescale 1ns/10ps
module occ_channel_properties (
  input wire logic hclk, // in
  input wire logic hresetn, // in
  input wire logic hsel, // in
  input wire logic [31:0] haddr, // in
  input wire logic [1:0] htrans, // in
  input wire logic hwrite, // in
  input wire logic [2:0] hsize, // in
  input wire logic [31:0] hwdata, // in
  input wire logic hready, // in
  input wire logic [31:0] hrdata, // out
  input wire logic hreadyout, // out
  input wire logic hresp, // out
  input wire occ_pkg::occ_ticks_t ticks, // in
  input wire occ_pkg::occ_trig_t trig, // in
  input wire logic cpu_idle, // in
  input wire logic fault_a_input_pin, // in
  input wire logic compare_output_pin, // out
  input wire logic irq // out
);
  import occ_pkg::*;
  logic wph_q;
  logic [7:0] adr_q;
  logic [15:0] c1_q;
  logic [15:0] msk_q;
  logic [3:0] icnt_q;
  logic [3:0] fcnt_q;
  logic rd_c1;
  logic [2:0] md;
  logic flt;
  logic [2:0] en_h_q;
  assign rd_c1 = hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_0000;
  assign md = c1_q[2:0];
  // hardware-set status is not shadowed, only written control
  assign flt = md[2] && md[1] && c1_q[7] && en_h_q[2] && fcnt_q == 4'hF;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q <= 1'b0;
      adr_q <= 8'h00;
      c1_q <= 16'h0000;
      msk_q <= 16'h0000;
      icnt_q <= 4'h0;
      fcnt_q <= 4'h0;
      en_h_q <= 3'h0;
    end else begin
      en_h_q <= {en_h_q[1:0], c1_q[7]};
      wph_q <= hsel && hready && htrans[1] && hwrite;
      adr_q <= haddr[7:0];
      if (wph_q && adr_q == OCC_ADDR_CTRL1) c1_q <= hwdata[15:0];
      if (wph_q && adr_q == OCC_ADDR_IMASK) msk_q <= hwdata[15:0];
      icnt_q <= cpu_idle ? icnt_q + {3'h0, ~&icnt_q} : 4'h0;
      fcnt_q <= fault_a_input_pin ? fcnt_q + {3'h0, ~&fcnt_q} : 4'h0;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_pad;
    rd_c1 |=> (hrdata & ~{16'h0000, OCC_C1_IMPL}) == 32'h0000_0000;
  endproperty
  a_pad: assert property (p_pad)
    else $error("control one pad bits set");
  property p_mask;
    msk_q == 16'h0000 && $past(msk_q) == 16'h0000 |-> !irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("irq while masked");
  property p_idle;
    c1_q[13] && icnt_q == 4'hF && !wph_q && !$past(wph_q) |=> $stable(compare_output_pin);
  endproperty
  a_idle: assert property (p_idle)
    else $error("pin moved in idle stop");
  property p_off;
    md == 3'b000 && $past(md) == 3'b000 && $past(md, 2) == 3'b000 |-> !compare_output_pin;
  endproperty
  a_off: assert property (p_off)
    else $error("pin high while off");
  property p_hi;
    $changed(md) && md == 3'b010 |-> ##[0:2] compare_output_pin;
  endproperty
  a_hi: assert property (p_hi)
    else $error("mode 010 did not start high");
  property p_lo;
    $changed(md) && md inside {3'b001, 3'b100, 3'b101} |-> ##[0:2] !compare_output_pin;
  endproperty
  a_lo: assert property (p_lo)
    else $error("mode did not start low");
  property p_flt;
    flt |-> !compare_output_pin;
  endproperty
  a_flt: assert property (p_flt)
    else $error("fault did not force low");
  property p_fst;
    flt && rd_c1 |=> hrdata[4];
  endproperty
  a_fst: assert property (p_fst)
    else $error("fault status not set");
  c_irq: cover property ($rose(irq));
  c_flt: cover property (flt);
  c_idle: cover property (c1_q[13] && icnt_q == 4'hF);
endmodule : occ_channel_properties
bind occ_channel occ_channel_properties i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .ticks, .trig, .cpu_idle,
  .fault_a_input_pin, .compare_output_pin, .irq);

// ---- verif/tb.sv ----
/* self-checking bench of the output compare channel.
   assumes zero-wait slave; time base shortened to 6 bits. */
`timescale 1ns/10ps
module tb;
  import occ_pkg::*;
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] edges;
    logic lvl;
  } occ_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  occ_ticks_t ticks = 5'h00;
  occ_trig_t trig = 2'b00;
  logic cpu_idle = 1'b0;
  logic flt = 1'b0;
  logic pin;
  logic irq;
  logic clr = 1'b0;
  logic [7:0] edges;
  logic [31:0] a;
  logic [31:0] b;
  int mismatches = 0;
  int n_compared = 0;
  // edges and level 40 cycles on, primary 10, secondary 20; pwm period ends at secondary
  occ_row_t rows [7] = '{'{3'd1, 8'd1, 1'b1}, '{3'd2, 8'd2, 1'b0}, '{3'd3, 8'd1, 1'b1},
    '{3'd4, 8'd2, 1'b0}, '{3'd5, 8'd2, 1'b0}, '{3'd6, 8'd4, 1'b0}, '{3'd7, 8'd3, 1'b1}};
  always #50 hclk = ~hclk;
  occ_channel #(.CNT_W(6)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ticks(ticks), .trig(trig), .cpu_idle(cpu_idle),
    .fault_a_input_pin(flt), .compare_output_pin(pin), .irq(irq));
  occ_load_model i_load (.hclk(hclk), .hresetn(hresetn), .pin(pin), .clr(clr), .edges(edges));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // each phase held until hready is seen high at a rising edge; data taken there
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, ad, 32'h0, r);
    check($sformatf("reg %h", ad), r, e);
  endtask : rchk
  task automatic pin_is(input logic e);
    @(negedge hclk);
    check("pin", {31'h0, pin}, {31'h0, e});
    @(posedge hclk);
  endtask : pin_is
  task automatic pulse;
    trig <= 2'b10;
    @(posedge hclk);
    trig <= 2'b00;
  endtask : pulse
  task automatic tk(input int n);
    repeat (6) begin
      ticks <= 5'(1 << n);
      @(posedge hclk);
      ticks <= 5'h00;
      @(posedge hclk);
    end
  endtask : tk
  task automatic results;
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(OCC_ADDR_CTRL1, 32'h0);
    rchk(OCC_ADDR_CTRL2, {16'h0, OCC_C2_RESET});
    rchk(8'h1C, 32'h0);
    xfer(1'b1, OCC_ADDR_CTRL1, 32'hFFFF_FFEF, a);
    rchk(OCC_ADDR_CTRL1, 32'h0000_3C8F);
    xfer(1'b1, OCC_ADDR_PRI, 32'd10, a);
    xfer(1'b1, OCC_ADDR_SEC, 32'd20, a);
    foreach (rows[i]) begin
      xfer(1'b1, OCC_ADDR_CTRL1, 32'h1C00, a);
      repeat (4) @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      xfer(1'b1, OCC_ADDR_CTRL1, {16'h0, 13'h0380, rows[i].mode}, a);
      pulse();
      repeat (40) @(posedge hclk);
      @(negedge hclk);
      check("edges", {24'h0, edges}, {24'h0, rows[i].edges});
      pin_is(rows[i].lvl);
    end
    xfer(1'b1, OCC_ADDR_CTRL1, 32'h0, a);
    pin_is(1'b0);
    check("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, OCC_ADDR_IMASK, 32'h1, a);
    repeat (2) @(posedge hclk);
    pin_is(1'b0);
    check("irq", {31'h0, irq}, 32'h1);
    rchk(OCC_ADDR_ISTAT, 32'h3);
    pin_is(1'b0);
    check("irq clear", {31'h0, irq}, 32'h0);
    rchk(OCC_ADDR_ISTAT, 32'h0);
    xfer(1'b1, OCC_ADDR_PRI, 32'd3, a);
    for (int c = 0; c < 5; c++) begin
      xfer(1'b1, OCC_ADDR_CTRL1, 32'h0, a);
      xfer(1'b1, OCC_ADDR_CTRL1, 32'h1 | 32'(c << 10), a);
      pulse();
      tk((c + 2) % 5);
      pin_is(1'b0);
      tk((c + 1) % 5);
      pin_is(1'b1);
    end
    cpu_idle <= 1'b1;
    for (int s = 1; s >= 0; s--) begin
      xfer(1'b1, OCC_ADDR_CTRL1, 32'h1C01 | 32'(s << 13), a);
      repeat (20) @(posedge hclk);
      xfer(1'b0, OCC_ADDR_TMR, 32'h0, a);
      repeat (9) @(posedge hclk);
      xfer(1'b0, OCC_ADDR_TMR, 32'h0, b);
      check("timer held", {31'h0, a === b}, 32'(s));
    end
    cpu_idle <= 1'b0;
    rchk(OCC_ADDR_CTRL2, 32'h00C0);
    xfer(1'b1, OCC_ADDR_PRI, 32'd10, a);
    xfer(1'b1, OCC_ADDR_CTRL1, 32'h1C0D, a);
    repeat (40) @(posedge hclk);
    rchk(OCC_ADDR_CTRL2, 32'h0080);
    rchk(OCC_ADDR_TMR, 32'h0);
    xfer(1'b1, OCC_ADDR_PRI, 32'd50, a);
    flt <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      xfer(1'b1, OCC_ADDR_CTRL1, 32'h0, a);
      xfer(1'b1, OCC_ADDR_CTRL1, 32'h1C06 | 32'(e << 7), a);
      pulse();
      repeat (20) @(posedge hclk);
      pin_is(e == 0);
      rchk(OCC_ADDR_CTRL1, 32'h1C06 | 32'(e * 8'h90));
    end
    flt <= 1'b0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(OCC_ADDR_CTRL1, 32'h0);
    results();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    results();
  end
endmodule : tb
